// file: tag_params.svh
`ifndef TAG_PARAMS_SVH
`define TAG_PARAMS_SVH
// Contract
// [R1] Read: flags, 20h, optional serial, block number
// [R2] Read reply: flags, lock byte if option, data
// [R3] Lock byte: bit0 locked, upper bits zero
// [R4] Read errors: 0Fh other, 10h bad block
// [R5] Write: flags, 21h, serial, block, data word; the code sends and checks the serial only with FLG_ADDR set
// [R6] Write reply after programming; flags only
// [R7] Reader stays quiet during write program cycle
// [R8] Write errors: 10h range, 12h locked, 13h
// [R9] Lock: 22h, block locked permanently, unwritable; the code clears every lock bit at reset
// [R10] Reader stays quiet during lock program cycle
// [R11] Lock errors: 10h range, 11h locked, 14h
// [R12] Reply starts response wait after end of frame
// [R13] Error reply: flags with error, code only

// ========================================
// Command codes, request flag bits and the reply error flag bit
`define CMD_READ            8'h20
`define CMD_WRITE           8'h21
`define CMD_LOCK            8'h22
`define FLG_ERROR           0
`define FLG_ADDR            5
`define FLG_OPTION          6
// ========================================
// Error codes
`define ERR_OTHER           8'h0f
`define ERR_RANGE           8'h10
`define ERR_ALREADY_LOCKED  8'h11
`define ERR_LOCKED          8'h12
`define ERR_NOT_PROG        8'h13
`define ERR_NOT_LOCKED      8'h14
// ========================================
// Timing at a 25 ns clock
`define CLK_PERIOD_NS       25
`define T1_NOM_NS           320900
`define PROG_STEP_NS        302000
`define PROG_STEPS          18
`define T1_CYCLES           (`T1_NOM_NS / `CLK_PERIOD_NS)
`define TW_CYCLES           (`T1_CYCLES + `PROG_STEPS * `PROG_STEP_NS / `CLK_PERIOD_NS)
`define RSP_TIMEOUT_CYCLES  (`TW_CYCLES + 2 * `T1_CYCLES)
// ========================================
// Sizes
`define NUM_BLOCKS          64
`define FIFO_DEPTH          16
// ========================================
// Reader control registers
`define REG_CTRL            8'h00
`define REG_UID_LO          8'h04
`define REG_UID_HI          8'h08
`define REG_WDATA           8'h0c
`define REG_STATUS          8'h10
`define REG_RDATA           8'h14
`define CTRL_START          31
`endif

// file: tag_pkg.sv
`include "tag_params.svh"
package tag_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [2:0] {D_RX, D_EVAL, D_PROG, D_WAIT, D_TX} dev_state_t;
	typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT} host_state_t;

	// Byte position of the block number, behind the optional serial
	function automatic logic [3:0] block_pos(input byte_t flags);
		return flags[`FLG_ADDR] ? 4'd10 : 4'd2;
	endfunction
endpackage

// file: tag_link_if.sv
`timescale 1ns/1ps
interface tag_link_if;
	logic       req_valid;
	logic       req_ready;
	logic [7:0] req_data;
	logic       req_last;
	logic       rsp_valid;
	logic [7:0] rsp_data;
	logic       rsp_last;

	modport tag (
		input  req_valid, req_data, req_last,
		output req_ready, rsp_valid, rsp_data, rsp_last
	);
	modport reader (
		output req_valid, req_data, req_last,
		input  req_ready, rsp_valid, rsp_data, rsp_last
	);
endinterface

// file: tag_fifo.sv
`timescale 1ns/1ps
`include "tag_params.svh"
module tag_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input  wire logic             i_clock,
	input  wire logic             i_nrst,
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	// Pointers wrap naturally, so DEPTH must be a power of two
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             rdy_nxt, push, pop;

	always_comb begin
		push    = i_in_valid & o_in_ready;
		pop     = o_out_valid & i_out_ready;
		wp_nxt  = push ? wp_r + 1'b1 : wp_r;
		rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		rdy_nxt = cnt_nxt != (AW+1)'(DEPTH);
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			wp_r       <= '0;
			rp_r       <= '0;
			cnt_r      <= '0;
			o_in_ready <= 1'b1;
		end else begin
			wp_r       <= wp_nxt;
			rp_r       <= rp_nxt;
			cnt_r      <= cnt_nxt;
			o_in_ready <= rdy_nxt;
		end
	end

	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_r[wp_r] <= i_in_data;
		end
	end

	assign o_out_valid = cnt_r != '0;
	assign o_out_data  = mem_r[rp_r];
endmodule // tag_fifo

// file: tag_end.sv
`timescale 1ns/1ps
`include "tag_params.svh"
module tag_end
	import tag_pkg::*;
#(
	parameter int T1_CYCLES  = `T1_CYCLES,
	parameter int TW_CYCLES  = `TW_CYCLES,
	parameter int NUM_BLOCKS = `NUM_BLOCKS
) (
	input  wire logic        I_CLOCK,
	input  wire logic        I_NRST,
	tag_link_if.tag          LINK,
	input  wire logic [63:0] I_TAG_UID,
	input  wire logic        I_PROG_FAULT,
	output logic             O_PROG_BUSY
);
	localparam int MAXB = 15;
	localparam int BW   = $clog2(NUM_BLOCKS);

	logic [8:0]            f_data;
	logic                  f_valid, f_ready, f_take;
	dev_state_t            st_r, st_nxt;
	byte_t                 rx_r [MAXB];
	byte_t                 rx_nxt [MAXB];
	logic [4:0]            rxn_r, rxn_nxt;
	logic                  ovf_r, ovf_nxt, mod_r, mod_nxt;
	logic                  islk_r, islk_nxt;
	logic [31:0]           cnt_r, cnt_nxt, data_r, data_nxt;
	logic [BW-1:0]         blk_r, blk_nxt, bi;
	logic [47:0]           rsp_r, rsp_nxt;
	logic [2:0]            left_r, left_nxt;
	logic                  rv_r, rv_nxt, rl_r, rl_nxt, busy_nxt;
	byte_t                 rd_r, rd_nxt;
	logic [31:0]           mem_r [NUM_BLOCKS];
	logic [NUM_BLOCKS-1:0] lock_r;
	logic                  mem_we, lock_we, fail;
	byte_t                 flags, cmd, blk8, ecode;
	logic [3:0]            pos;
	logic [63:0]           tag_serial_identifier;
	logic [31:0]           wd;
	logic                  known, uid_ok, len_bad;

	// ========================================
	// Request buffer; stalls while the tag is busy so the link backs up
	assign f_ready = st_r == D_RX;
	assign f_take  = f_valid & f_ready;

	tag_fifo #(
		.WIDTH (9),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.i_clock     (I_CLOCK),
		.i_nrst      (I_NRST),
		.i_in_valid  (LINK.req_valid),
		.i_in_data   ({LINK.req_last, LINK.req_data}),
		.o_in_ready  (LINK.req_ready),
		.o_out_valid (f_valid),
		.o_out_data  (f_data),
		.i_out_ready (f_ready)
	);

	// ========================================
	// Request field decode
	always_comb begin
		flags = rx_r[0];
		cmd   = rx_r[1];
		pos   = block_pos(flags);
		blk8  = rx_r[pos];
		bi    = blk8[BW-1:0];
		for (int i = 0; i < 8; i++) begin
			tag_serial_identifier[8*i +: 8] = rx_r[2 + i];
		end
		for (int i = 0; i < 4; i++) begin
			wd[8*i +: 8] = rx_r[pos + 4'(i + 1)];
		end
		known   = cmd == `CMD_READ || cmd == `CMD_WRITE || cmd == `CMD_LOCK; // see [R1] [R5] [R9]
		uid_ok  = !flags[`FLG_ADDR] || tag_serial_identifier == I_TAG_UID;
		len_bad = ovf_r || rxn_r != {1'b0, pos + ((cmd == `CMD_WRITE) ? 4'd5 : 4'd1)};
		if (len_bad) begin
			ecode = `ERR_OTHER; // see [R4]
		end else if (blk8 >= 8'(NUM_BLOCKS)) begin
			ecode = `ERR_RANGE; // see [R4] [R8] [R11]
		end else if (cmd != `CMD_READ && lock_r[bi]) begin
			ecode = (cmd == `CMD_WRITE) ? `ERR_LOCKED : `ERR_ALREADY_LOCKED; // see [R8] [R11]
		end else begin
			ecode = 8'h00;
		end
	end

	// ========================================
	// Command sequencer
	always_comb begin
		st_nxt   = st_r;
		rx_nxt   = rx_r;
		rxn_nxt  = rxn_r;
		ovf_nxt  = ovf_r;
		mod_nxt  = mod_r;
		islk_nxt = islk_r;
		cnt_nxt  = cnt_r;
		data_nxt = data_r;
		blk_nxt  = blk_r;
		rsp_nxt  = rsp_r;
		left_nxt = left_r;
		rv_nxt   = rv_r;
		rl_nxt   = rl_r;
		rd_nxt   = rd_r;
		mem_we   = 1'b0;
		lock_we  = 1'b0;
		fail     = mod_r | LINK.req_valid | I_PROG_FAULT;
		case (st_r)
			D_RX: begin
				if (f_take) begin
					if (rxn_r < 5'(MAXB)) begin
						rx_nxt[rxn_r[3:0]] = f_data[7:0];
						rxn_nxt            = rxn_r + 5'd1;
					end else begin
						ovf_nxt = 1'b1;
					end
					if (f_data[8]) begin
						st_nxt = D_EVAL;
					end
				end
			end
			D_EVAL: begin
				rxn_nxt  = '0;
				ovf_nxt  = 1'b0;
				mod_nxt  = 1'b0;
				blk_nxt  = bi;
				data_nxt = wd;
				islk_nxt = cmd == `CMD_LOCK;
				st_nxt   = D_WAIT;
				cnt_nxt  = 32'(T1_CYCLES - 3); // see [R12]
				// Frames not for this tag or not handled here get no answer
				if (rxn_r < 5'd2 || !known || !uid_ok) begin
					st_nxt = D_RX;
				end else if (ecode != 8'h00) begin
					rsp_nxt  = {32'h0, ecode, 8'h01}; // see [R13]
					left_nxt = 3'd2;
				end else if (cmd == `CMD_READ) begin
					if (flags[`FLG_OPTION]) begin
						rsp_nxt  = {mem_r[bi], 7'h00, lock_r[bi], 8'h00}; // see [R2] [R3]
						left_nxt = 3'd6;
					end else begin
						rsp_nxt  = {8'h00, mem_r[bi], 8'h00}; // see [R2]
						left_nxt = 3'd5;
					end
				end else begin
					st_nxt  = D_PROG;
					cnt_nxt = 32'(TW_CYCLES - 1); // see [R6]
				end
			end
			D_PROG: begin
				cnt_nxt = cnt_r - 32'd1;
				// Any frame activity now may corrupt the cell, so it fails the job
				if (LINK.req_valid) begin
					mod_nxt = 1'b1; // see [R7] [R10]
				end
				if (cnt_r == 32'd0) begin
					st_nxt   = D_WAIT;
					cnt_nxt  = 32'(T1_CYCLES - 3); // see [R12]
					mem_we   = !fail && !islk_r; // see [R5]
					lock_we  = !fail && islk_r; // see [R9]
					left_nxt = fail ? 3'd2 : 3'd1; // see [R6]
					rsp_nxt  = {32'h0, islk_r ? `ERR_NOT_LOCKED : `ERR_NOT_PROG,
						7'h00, fail}; // see [R8] [R11]
				end
			end
			D_WAIT: begin
				cnt_nxt = cnt_r - 32'd1;
				if (cnt_r == 32'd0) begin
					st_nxt = D_TX;
				end
			end
			D_TX: begin
				if (rl_r) begin
					rv_nxt = 1'b0;
					rl_nxt = 1'b0;
					st_nxt = D_RX;
				end else begin
					rv_nxt   = 1'b1;
					rd_nxt   = rsp_r[7:0];
					rl_nxt   = left_r == 3'd1;
					rsp_nxt  = rsp_r >> 8;
					left_nxt = left_r - 3'd1;
				end
			end
			default: begin
				st_nxt = D_RX;
			end
		endcase
		busy_nxt = st_nxt == D_PROG;
	end

	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			st_r        <= D_RX;
			rx_r        <= '{default: '0};
			rxn_r       <= '0;
			ovf_r       <= 1'b0;
			mod_r       <= 1'b0;
			islk_r      <= 1'b0;
			cnt_r       <= '0;
			data_r      <= '0;
			blk_r       <= '0;
			rsp_r       <= '0;
			left_r      <= '0;
			rv_r        <= 1'b0;
			rl_r        <= 1'b0;
			rd_r        <= '0;
			O_PROG_BUSY <= 1'b0;
		end else begin
			st_r        <= st_nxt;
			rx_r        <= rx_nxt;
			rxn_r       <= rxn_nxt;
			ovf_r       <= ovf_nxt;
			mod_r       <= mod_nxt;
			islk_r      <= islk_nxt;
			cnt_r       <= cnt_nxt;
			data_r      <= data_nxt;
			blk_r       <= blk_nxt;
			rsp_r       <= rsp_nxt;
			left_r      <= left_nxt;
			rv_r        <= rv_nxt;
			rl_r        <= rl_nxt;
			rd_r        <= rd_nxt;
			O_PROG_BUSY <= busy_nxt;
		end
	end

	// ========================================
	// Block store; lock bits model the permanent fuse but clear at power-up
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			mem_r  <= '{default: '0};
			lock_r <= '0;
		end else begin
			if (mem_we) begin
				mem_r[blk_r] <= data_r;
			end
			if (lock_we) begin
				lock_r[blk_r] <= 1'b1;
			end
		end
	end

	assign LINK.rsp_valid = rv_r;
	assign LINK.rsp_data  = rd_r;
	assign LINK.rsp_last  = rl_r;
endmodule // tag_end

// file: reader_end.sv
`timescale 1ns/1ps
`include "tag_params.svh"
module reader_end
	import tag_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = `RSP_TIMEOUT_CYCLES
) (
	input  wire logic        I_CLOCK,
	input  wire logic        I_NRST,
	tag_link_if.reader       LINK,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR
);
	host_state_t  st_r, st_nxt;
	byte_t        cmd_r, cmd_nxt, blk_r, blk_nxt, code_r, code_nxt, lk_r, lk_nxt;
	byte_t        qd_r, qd_nxt, fl;
	logic         opt_r, opt_nxt, adr_r, adr_nxt;
	logic [63:0]  uid_r, uid_nxt;
	logic [31:0]  wd_r, wd_nxt, rd_r, rd_nxt, cnt_r, cnt_nxt, prdata_nxt;
	logic [119:0] tx_r, tx_nxt;
	logic [3:0]   left_r, left_nxt;
	logic [47:0]  rx_r, rx_nxt, word;
	logic [2:0]   rxn_r, rxn_nxt;
	logic         done_r, done_nxt, err_r, err_nxt, noans_r, noans_nxt;
	logic         qv_r, qv_nxt, ql_r, ql_nxt, pready_nxt, pslverr_nxt, wr;

	always_comb begin
		st_nxt = st_r;
		cmd_nxt = cmd_r;
		blk_nxt = blk_r;
		opt_nxt = opt_r;
		adr_nxt = adr_r;
		uid_nxt = uid_r;
		wd_nxt = wd_r;
		rd_nxt = rd_r;
		code_nxt = code_r;
		lk_nxt = lk_r;
		cnt_nxt = cnt_r;
		tx_nxt = tx_r;
		left_nxt = left_r;
		rx_nxt = rx_r;
		rxn_nxt = rxn_r;
		done_nxt = done_r;
		err_nxt = err_r;
		noans_nxt = noans_r;
		qv_nxt = qv_r;
		ql_nxt = ql_r;
		qd_nxt = qd_r;
		word = {LINK.rsp_data, rx_r[47:8]} >> (8 * (3'd5 - rxn_r));
		fl = {1'b0, I_PWDATA[8], I_PWDATA[9], 5'h00};
		// ========================================
		// Frame transmit and answer collection
		case (st_r)
			H_IDLE: begin
			end
			H_SEND: begin
				if (!qv_r || LINK.req_ready) begin
					if (left_r != 4'd0) begin
						qv_nxt = 1'b1;
						qd_nxt = tx_r[7:0];
						ql_nxt = left_r == 4'd1;
						tx_nxt = tx_r >> 8;
						left_nxt = left_r - 4'd1;
					end else begin
						qv_nxt = 1'b0;
						ql_nxt = 1'b0;
						st_nxt = H_WAIT;
						cnt_nxt = 32'(TIMEOUT_CYCLES);
						rxn_nxt = '0;
					end
				end
			end
			H_WAIT: begin
				// Nothing is sent until the answer, which covers the program cycle
				cnt_nxt = cnt_r - 32'd1; // see [R7] [R10]
				if (LINK.rsp_valid) begin
					rx_nxt = {LINK.rsp_data, rx_r[47:8]};
					rxn_nxt = (rxn_r == 3'd5) ? rxn_r : rxn_r + 3'd1;
					if (LINK.rsp_last) begin
						st_nxt = H_IDLE;
						done_nxt = 1'b1;
						err_nxt = word[`FLG_ERROR];
						if (word[`FLG_ERROR]) begin
							code_nxt = word[15:8]; // see [R13]
						end else if (cmd_r == `CMD_READ) begin
							lk_nxt = opt_r ? word[15:8] : 8'h00; // see [R2]
							rd_nxt = opt_r ? word[47:16] : word[39:8];
						end
					end
				end else if (cnt_r == 32'd0) begin
					st_nxt = H_IDLE;
					done_nxt = 1'b1;
					noans_nxt = 1'b1;
				end
			end
			default: begin
				st_nxt = H_IDLE;
			end
		endcase
		// ========================================
		// APB slave: write lands on the edge that completes the access
		pready_nxt = I_PSEL & I_PENABLE & !O_PREADY;
		wr = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
		pslverr_nxt = 1'b0;
		case (I_PADDR)
			`REG_CTRL: prdata_nxt = {8'h00, blk_r, 6'h00, adr_r, opt_r, cmd_r};
			`REG_UID_LO: prdata_nxt = uid_r[31:0];
			`REG_UID_HI: prdata_nxt = uid_r[63:32];
			`REG_WDATA: prdata_nxt = wd_r;
			`REG_STATUS: prdata_nxt = {8'h00, lk_r, code_r, 4'h0, noans_r, err_r, done_r,
				st_r != H_IDLE};
			`REG_RDATA: prdata_nxt = rd_r;
			default: begin
				prdata_nxt = 32'h0;
				pslverr_nxt = pready_nxt;
			end
		endcase
		if (wr) begin
			case (I_PADDR)
				`REG_CTRL: begin
					cmd_nxt = I_PWDATA[7:0];
					opt_nxt = I_PWDATA[8];
					adr_nxt = I_PWDATA[9];
					blk_nxt = I_PWDATA[23:16];
					if (I_PWDATA[`CTRL_START] && st_r == H_IDLE) begin
						tx_nxt = I_PWDATA[9]
							? {wd_r, I_PWDATA[23:16], uid_r, I_PWDATA[7:0], fl}
							: {64'h0, wd_r, I_PWDATA[23:16], I_PWDATA[7:0], fl}; // see [R1] [R5] [R9]
						left_nxt = 4'd3 + (I_PWDATA[9] ? 4'd8 : 4'd0)
							+ ((I_PWDATA[7:0] == `CMD_WRITE) ? 4'd4 : 4'd0);
						st_nxt = H_SEND;
						done_nxt = 1'b0;
						err_nxt = 1'b0;
						noans_nxt = 1'b0;
					end
				end
				`REG_UID_LO: uid_nxt[31:0] = I_PWDATA;
				`REG_UID_HI: uid_nxt[63:32] = I_PWDATA;
				`REG_WDATA: wd_nxt = I_PWDATA;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			st_r <= H_IDLE;
			{cmd_r, blk_r, code_r, lk_r, qd_r} <= '0;
			{opt_r, adr_r, done_r, err_r, noans_r, qv_r, ql_r} <= '0;
			{uid_r, wd_r, rd_r, cnt_r} <= '0;
			{tx_r, left_r, rx_r, rxn_r} <= '0;
			{O_PRDATA, O_PREADY, O_PSLVERR} <= '0;
		end else begin
			st_r <= st_nxt;
			{cmd_r, blk_r, code_r, lk_r, qd_r} <= {cmd_nxt, blk_nxt, code_nxt, lk_nxt, qd_nxt};
			{opt_r, adr_r, done_r, err_r, noans_r, qv_r, ql_r}
				<= {opt_nxt, adr_nxt, done_nxt, err_nxt, noans_nxt, qv_nxt, ql_nxt};
			{uid_r, wd_r, rd_r, cnt_r} <= {uid_nxt, wd_nxt, rd_nxt, cnt_nxt};
			{tx_r, left_r, rx_r, rxn_r} <= {tx_nxt, left_nxt, rx_nxt, rxn_nxt};
			{O_PRDATA, O_PREADY, O_PSLVERR} <= {prdata_nxt, pready_nxt, pslverr_nxt};
		end
	end

	assign LINK.req_valid = qv_r;
	assign LINK.req_data  = qd_r;
	assign LINK.req_last  = ql_r;
endmodule // reader_end

// file: tag_link_chk.sv
`timescale 1ns/1ps
`include "tag_params.svh"
module tag_link_chk #(
	parameter int T1_CYCLES = `T1_CYCLES
) (
	input  wire logic       I_CLOCK,
	input  wire logic       I_NRST,
	input  wire logic       req_valid,
	input  wire logic       req_ready,
	input  wire logic [7:0] req_data,
	input  wire logic       req_last,
	input  wire logic       rsp_valid,
	input  wire logic [7:0] rsp_data,
	input  wire logic       rsp_last,
	input  wire logic       O_PROG_BUSY
);
	// ========================================
	// Frame tracking: command byte and cycles since end of frame
	logic [15:0] gap_r, gap_nxt;
	logic [3:0]  idx_r, idx_nxt;
	logic [7:0]  cmd_r, cmd_nxt;
	logic        take;

	assign take = req_valid && req_ready;

	always_comb begin
		gap_nxt = (gap_r == 16'hffff) ? gap_r : gap_r + 16'h1;
		idx_nxt = idx_r;
		cmd_nxt = cmd_r;
		if (take) begin
			idx_nxt = req_last ? 4'h0 : idx_r + 4'h1;
			if (idx_r == 4'h1)
				cmd_nxt = req_data;
			if (req_last)
				gap_nxt = 16'h0;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			gap_r <= 16'h0;
			idx_r <= 4'h0;
			cmd_r <= 8'h00;
		end else begin
			gap_r <= gap_nxt;
			idx_r <= idx_nxt;
			cmd_r <= cmd_nxt;
		end
	end

	// ========================================
	// Link properties
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_NRST);

	property p_req_hold;
		req_valid && !req_ready |=> req_valid && $stable(req_data) && $stable(req_last);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request byte not held");
	property p_rsp_wait;
		$rose(rsp_valid) |-> gap_r >= T1_CYCLES;
	endproperty
	a_rsp_wait: assert property (p_rsp_wait) else $error("response started too early");
	property p_flags;
		$rose(rsp_valid) |-> rsp_data[7:1] == 7'h00;
	endproperty
	a_flags: assert property (p_flags) else $error("response flags malformed");
	property p_err_two;
		$rose(rsp_valid) && rsp_data[0] |-> !rsp_last ##1 (rsp_valid && rsp_last);
	endproperty
	a_err_two: assert property (p_err_two) else $error("error reply not two bytes");
	property p_err_code;
		$rose(rsp_valid) && rsp_data[0] |=>
			(cmd_r == `CMD_READ && rsp_data inside {`ERR_OTHER, `ERR_RANGE}) ||
			(cmd_r == `CMD_WRITE && rsp_data inside {`ERR_OTHER, `ERR_RANGE, `ERR_LOCKED,
				`ERR_NOT_PROG}) ||
			(cmd_r == `CMD_LOCK && rsp_data inside {`ERR_OTHER, `ERR_RANGE,
				`ERR_ALREADY_LOCKED, `ERR_NOT_LOCKED});
	endproperty
	a_err_code: assert property (p_err_code) else $error("bad error code");
	property p_ok_short;
		$rose(rsp_valid) && rsp_last |-> rsp_data == 8'h00 && cmd_r != `CMD_READ;
	endproperty
	a_ok_short: assert property (p_ok_short) else $error("one byte reply malformed");
	property p_read_len;
		$rose(rsp_valid) && !rsp_data[0] && cmd_r == `CMD_READ |->
			((rsp_valid && !rsp_last)[*4] ##1 (rsp_valid && rsp_last)) or
			((rsp_valid && !rsp_last)[*5] ##1 (rsp_valid && rsp_last));
	endproperty
	a_read_len: assert property (p_read_len) else $error("read reply length wrong");
	property p_lock_byte;
		$rose(rsp_valid) && !rsp_data[0] && cmd_r == `CMD_READ ##5 rsp_last |->
			($past(rsp_data, 4) & 8'hfe) == 8'h00;
	endproperty
	a_lock_byte: assert property (p_lock_byte) else $error("lock byte upper bits set");
	property p_rsp_end;
		rsp_valid && rsp_last |=> !rsp_valid;
	endproperty
	a_rsp_end: assert property (p_rsp_end) else $error("bytes after last byte");
	property p_quiet;
		O_PROG_BUSY |-> !req_valid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("request while programming");
endmodule // tag_link_chk

// file: block_read_write_lock_handler_bench.sv
`timescale 1ns/1ps
`include "tag_params.svh"
module block_read_write_lock_handler_bench;
	localparam int          T1     = 10;
	localparam int          TW     = 40;
	localparam int          PG     = TW + T1;
	localparam logic [63:0] SERIAL = 64'h0123456789abcdef; // Arbitrary serial
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, fault, busy, busy_b, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, dd;
	logic [63:0] ser;
	logic [7:0]  req_q[$], rsp_q[$], rsp_b[$];
	int          mismatches, checks_done, cyc, eof_cyc, gap;

	tag_link_if lnk();
	tag_link_if lnk_b();
	tag_end #(.T1_CYCLES(T1), .TW_CYCLES(TW)) tag_end_inst (.I_CLOCK(clk), .I_NRST(nrst),
		.LINK(lnk), .I_TAG_UID(SERIAL), .I_PROG_FAULT(fault), .O_PROG_BUSY(busy));
	reader_end #(.TIMEOUT_CYCLES(TW + 2 * T1 + 20)) reader_end_inst (.I_CLOCK(clk),
		.I_NRST(nrst), .LINK(lnk), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr));
	// Second tag faces the bench directly so the reader side can misbehave
	tag_end #(.T1_CYCLES(T1), .TW_CYCLES(TW)) tag_end_inst_b (.I_CLOCK(clk), .I_NRST(nrst),
		.LINK(lnk_b), .I_TAG_UID(SERIAL), .I_PROG_FAULT(1'b0), .O_PROG_BUSY(busy_b));
	tag_link_chk #(.T1_CYCLES(T1)) tag_link_chk_inst (.I_CLOCK(clk), .I_NRST(nrst),
		.req_valid(lnk.req_valid), .req_ready(lnk.req_ready), .req_data(lnk.req_data),
		.req_last(lnk.req_last), .rsp_valid(lnk.rsp_valid), .rsp_data(lnk.rsp_data),
		.rsp_last(lnk.rsp_last), .O_PROG_BUSY(busy));

	// ========================================
	// Clock, wire monitor and watchdog
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (lnk.req_valid && lnk.req_ready) begin
			req_q.push_back(lnk.req_data);
			if (lnk.req_last)
				eof_cyc = cyc;
		end
		if (lnk.rsp_valid) begin
			if (rsp_q.size() == 0)
				gap = cyc - eof_cyc;
			rsp_q.push_back(lnk.rsp_data);
		end
		if (lnk_b.rsp_valid)
			rsp_b.push_back(lnk_b.rsp_data);
		if (cyc > 20000) begin
			mismatches++;
			close_out();
		end
	end

	// ========================================
	// Tasks
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One command through the reader registers; ex holds the reply, first byte on top
	task automatic run(input logic [7:0] c, input logic o, input logic a, input logic [7:0] b,
		input logic [31:0] wd, input int n, input logic [47:0] ex, input int g0);
		logic [31:0] st;
		int          p, k;
		apb(1'b1, `REG_WDATA, wd, st, e);
		req_q.delete();
		rsp_q.delete();
		apb(1'b1, `REG_CTRL, {1'b1, 7'h00, b, 6'h00, a, o, c}, st, e);
		k = 0;
		do begin
			apb(1'b0, `REG_STATUS, 32'h0, st, e);
			k++;
		end while (st[0] !== 1'b0 && k < 100);
		p = a ? 10 : 2;
		chk(req_q.size(), p + 1 + ((c == `CMD_WRITE) ? 4 : 0), "request length");
		chk(req_q[1], c, "command code");
		chk(req_q[0] & 8'h60, {1'b0, o, a, 5'h00}, "request flags");
		for (k = 0; k < 8 * a; k++)
			chk(req_q[2 + k], ser[8 * k +: 8], "serial byte");
		chk(req_q[p], b, "block number");
		for (k = 0; k < 4 * (c == `CMD_WRITE); k++)
			chk(req_q[p + 1 + k], wd[8 * k +: 8], "data byte");
		chk(rsp_q.size(), n, "reply length");
		for (k = 0; k < n; k++)
			chk(rsp_q[k], ex[8 * (n - 1 - k) +: 8], "reply byte");
		if (n > 0)
			chk(gap >= g0 && gap <= g0 + 6, 1, "reply delay");
		chk(st[3], n == 0, "no answer flag");
		if (n == 2)
			chk(st[15:8], ex[7:0], "status error code");
		if (n == 6)
			chk(st[23:16], ex[39:32], "status lock byte");
		if (n >= 5) begin
			apb(1'b0, `REG_RDATA, 32'h0, st, e);
			chk(st, {ex[7:0], ex[15:8], ex[23:16], ex[31:24]}, "read data");
		end
	endtask

	// Bench in the reader role on the second link; call right after an edge
	task automatic frame_b(input logic [55:0] f, input int n);
		int k;
		for (k = 0; k < n; k++) begin
			lnk_b.req_valid <= 1'b1;
			lnk_b.req_data <= f[8 * k +: 8];
			lnk_b.req_last <= (k == n - 1);
			do begin
				@(posedge clk);
			end while (lnk_b.req_ready !== 1'b1);
		end
		lnk_b.req_valid <= 1'b0;
	endtask

	task automatic wait_b(input int n);
		int k;
		for (k = 0; k < 300 && rsp_b.size() < n; k++)
			@(posedge clk);
	endtask

	// ========================================
	// Main sequence
	initial begin
		nrst = 1'b0;
		{psel, penable, pwrite, fault} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		{lnk_b.req_valid, lnk_b.req_data, lnk_b.req_last} = 10'h000;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		ser = SERIAL;
		apb(1'b1, `REG_UID_LO, ser[31:0], dd, e);
		apb(1'b1, `REG_UID_HI, ser[63:32], dd, e);
		apb(1'b0, 8'h18, 32'h0, dd, e);
		chk({e, dd}, 33'h1_0000_0000, "unmapped access");
		run(`CMD_READ, 1'b0, 1'b0, 8'd5, 32'h0, 5, 48'h0, T1);
		run(`CMD_WRITE, 1'b0, 1'b1, 8'd5, 32'ha1b2c3d4, 1, 48'h0, PG);
		run(`CMD_READ, 1'b1, 1'b1, 8'd5, 32'h0, 6, 48'h00_00_d4c3b2a1, T1);
		run(`CMD_LOCK, 1'b0, 1'b0, 8'd5, 32'h0, 1, 48'h0, PG);
		run(`CMD_READ, 1'b1, 1'b0, 8'd5, 32'h0, 6, 48'h00_01_d4c3b2a1, T1);
		run(`CMD_WRITE, 1'b0, 1'b0, 8'd5, 32'h55aa55aa, 2, 48'h0112, T1);
		run(`CMD_LOCK, 1'b0, 1'b0, 8'd5, 32'h0, 2, 48'h0111, T1);
		run(`CMD_READ, 1'b0, 1'b0, 8'd64, 32'h0, 2, 48'h0110, T1);
		run(`CMD_WRITE, 1'b0, 1'b0, 8'd64, 32'h0, 2, 48'h0110, T1);
		run(`CMD_LOCK, 1'b0, 1'b0, 8'd255, 32'h0, 2, 48'h0110, T1);
		run(`CMD_WRITE, 1'b0, 1'b0, 8'd63, 32'h12345678, 1, 48'h0, PG);
		run(`CMD_READ, 1'b0, 1'b0, 8'd63, 32'h0, 5, 48'h00_78563412, T1);
		apb(1'b0, `REG_CTRL, 32'h0, dd, e);
		chk(dd[31], 1'b0, "start bit reads zero");
		@(posedge clk);
		fault <= 1'b1;
		run(`CMD_LOCK, 1'b0, 1'b0, 8'd6, 32'h0, 2, 48'h0114, PG);
		run(`CMD_WRITE, 1'b0, 1'b0, 8'd6, 32'hffffffff, 2, 48'h0113, PG);
		fault <= 1'b0;
		run(`CMD_WRITE, 1'b0, 1'b0, 8'd6, 32'h0000ffff, 1, 48'h0, PG);
		run(`CMD_READ, 1'b0, 1'b0, 8'd6, 32'h0, 5, 48'h00_ffff0000, T1);
		// A foreign serial must be ignored by the tag
		ser = SERIAL ^ 64'h1;
		apb(1'b1, `REG_UID_LO, ser[31:0], dd, e);
		run(`CMD_READ, 1'b0, 1'b1, 8'd5, 32'h0, 0, 48'h0, 0);
		// Second link: short frame, then modulation inside the program cycle
		@(posedge clk);
		frame_b(56'h2000, 2);
		wait_b(2);
		chk({rsp_b[0], rsp_b[1]}, 16'h010f, "short frame error");
		rsp_b.delete();
		frame_b(56'hddccbbaa_03_21_00, 7);
		for (int k = 0; k < 100 && busy_b !== 1'b1; k++)
			@(posedge clk);
		frame_b(56'h0, 1);
		wait_b(2);
		chk({rsp_b[0], rsp_b[1]}, 16'h0113, "disturbed write error");
		rsp_b.delete();
		@(posedge clk);
		frame_b(56'h03_20_00, 3);
		wait_b(5);
		chk({rsp_b[0], rsp_b[1], rsp_b[2], rsp_b[3], rsp_b[4]}, 40'h0, "unchanged");
		close_out();
	end
endmodule // block_read_write_lock_handler_bench
